// file: brs_pkg.sv
// Constants and types for the buck regulator supervisor
//
// Function
// - Switching clock is divided from mclk, stays synchronous to it.
// - Spread-spectrum is off after reset; software bit enables it.
// - Spread-spectrum varies period pseudo-randomly, about ten percent.
// - High-side overcurrent turns the high-side switch off.
// - Low-side overcurrent turns low-side off; node floats to next cycle.
// - After soft-start, output below 64 percent: disable 22 ms, set fault.
// - Off-time expiry restarts through full soft-start.
// - Persistent fault repeats off-time and restart indefinitely.
// - Hiccup ends when output reaches 95 percent of target.
// - Good flag is one only above 95 percent and in normal run.
// - Output below 95 percent asserts reset output, good flag zero.
// - Fault flag set on overload, below 64 percent, or in hiccup.
// - Fault flag clears itself on return to normal operation.
// - Soft-start runs DCM, then software-selected mode.
// - Soft-start reaches 95 percent within about 2.22 ms.
// - Mode bits: 00 PWM, PFM bit alone PFM, DCM bit wins.
// - Regulator enabled after reset; disable bit stops it.
package brs_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int OFF_TIME_US = 22000;
	localparam int OFF_TIME_CYC = OFF_TIME_US * CLK_MHZ;
	localparam int SOFT_START_NS = 2220000;
	localparam int SOFT_START_CYC = SOFT_START_NS / 8;
	localparam int SW_DIV = 128;
	localparam int SS_SPAN = SW_DIV / 10;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_MODE = 4'h4;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
	localparam int BIT_DIS = 0;
	localparam int BIT_SS = 1;
	localparam int BIT_PFM = 2;
	localparam int BIT_DCM = 3;
	localparam int BIT_GOOD = 0;
	localparam int BIT_FAULT = 1;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		BRS_PWM,
		BRS_PFM,
		BRS_DCM
	} brs_mode_e;
	typedef enum {
		ST_OFF,
		ST_SOFT,
		ST_RUN,
		ST_HICCUP
	} brs_state_e;
endpackage : brs_pkg

// file: brs_top.sv
// Digital supervisor for the on-chip buck regulator
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module brs_top #(
	parameter int OFF_CYC = brs_pkg::OFF_TIME_CYC,
	parameter int SOFT_CYC = brs_pkg::SOFT_START_CYC
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic hs_over_async,
	input wire logic ls_over_async,
	input wire logic above_95_async,
	input wire logic above_64_async,
	input wire logic uvlo_ok_async,
	output logic sw_clk,
	output logic hs_allow,
	output logic ls_allow,
	output logic switch_node_float,
	output logic reg_enable,
	output logic [1:0] conv_mode,
	output logic reset_n,
	output logic irq
);
	import brs_pkg::*;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int NIN = 5;
	logic [NIN-1:0] sync1;
	logic [NIN-1:0] sync2;
	wire [NIN-1:0] raw_in = {uvlo_ok_async, above_64_async, above_95_async,
		ls_over_async, hs_over_async};
	// Two stages; only the second is read by logic
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= '0;
			sync2 <= '0;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end
	wire hs_over = sync2[0];
	wire ls_over = sync2[1];
	wire above_95 = sync2[2];
	wire above_64 = sync2[3];
	wire uvlo_ok = sync2[4];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] mode_reg;
	logic [7:0] irq_mask;
	logic [7:0] irq_stat;
	wire ss_en = mode_reg[BIT_SS];
	wire sw_dis = mode_reg[BIT_DIS];
	wire wr_mode = wr && addr == ADDR_MODE;
	wire wr_mask = wr && addr == ADDR_IRQ_MASK;
	wire rd_stat = rd && addr == ADDR_IRQ_STAT;
	// Both reset to zero: enabled, no spread spectrum
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= MODE_RESET;
			irq_mask <= MASK_RESET;
		end else begin
			if (wr_mode)
				mode_reg <= wdata;
			if (wr_mask)
				irq_mask <= wdata;
		end
	end

	// ----------------------------------------
	// Switching clock with spread spectrum
	// ----------------------------------------
	logic [7:0] div_cnt;
	logic [7:0] period;
	logic [15:0] lfsr;
	wire [15:0] next_lfsr = {lfsr[14:0],
		lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
	// Offset in 0..2*SS_SPAN then centred, keeps deviation near ten percent
	wire [7:0] rnd_ofs = 8'(lfsr[7:0] % (2 * SS_SPAN + 1));
	wire [7:0] next_period = ss_en ? 8'(SW_DIV - SS_SPAN) + rnd_ofs
		: 8'(SW_DIV);
	wire cyc_end = div_cnt >= period - 8'h01;
	// Counted straight off mclk so the two never drift
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt <= '0;
			period <= 8'(SW_DIV);
			lfsr <= LFSR_SEED;
			sw_clk <= 1'b0;
		end else begin
			lfsr <= next_lfsr;
			div_cnt <= cyc_end ? 8'h00 : div_cnt + 8'h01;
			if (cyc_end)
				period <= next_period;
			sw_clk <= div_cnt < (period >> 1);
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	brs_state_e state;
	brs_state_e next_state;
	logic [31:0] tmr;
	wire tmr_off_done = tmr >= 32'(OFF_CYC - 1);
	wire tmr_soft_done = tmr >= 32'(SOFT_CYC - 1);
	// Next state of the power sequence
	always_comb begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (uvlo_ok && !sw_dis)
					next_state = ST_SOFT;
			end
			ST_SOFT: begin
				// Reaching 95 percent ends soft start or a retry
				if (sw_dis || !uvlo_ok)
					next_state = ST_OFF;
				else if (above_95)
					next_state = ST_RUN;
				else if (tmr_soft_done)
					next_state = ST_HICCUP;
			end
			ST_RUN: begin
				if (sw_dis || !uvlo_ok)
					next_state = ST_OFF;
				else if (!above_64)
					next_state = ST_HICCUP;
			end
			ST_HICCUP: begin
				if (sw_dis)
					next_state = ST_OFF;
				else if (tmr_off_done)
					next_state = ST_SOFT;
			end
			default: next_state = ST_OFF;
		endcase
	end
	// Timer restarts on every state change; off-time counted on mclk
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_OFF;
			tmr <= '0;
		end else begin
			state <= next_state;
			tmr <= (next_state != state) ? 32'h0 : tmr + 32'h1;
		end
	end

	// ----------------------------------------
	// Power stage controls and flags
	// ----------------------------------------
	wire running = state == ST_SOFT || state == ST_RUN;
	wire [1:0] sel_mode = mode_reg[BIT_DCM] ? 2'(BRS_DCM)
		: mode_reg[BIT_PFM] ? 2'(BRS_PFM) : 2'(BRS_PWM);
	wire [1:0] next_mode = state == ST_RUN ? sel_mode
		: 2'(BRS_DCM);
	// Retry soft-start still counts as hiccup, so the fault flag holds
	// until the output is good again
	logic in_retry;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			in_retry <= 1'b0;
		else if (next_state == ST_HICCUP)
			in_retry <= 1'b1;
		else if (next_state == ST_RUN || next_state == ST_OFF)
			in_retry <= 1'b0;
	end
	logic ls_trip;
	wire good = above_95 && state == ST_RUN;
	wire fault = hs_over || ls_over || in_retry
		|| (state == ST_RUN && !above_64);
	// Low-side trip holds until the next switching period; a trip on
	// the period boundary wins, so it is never lost
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			ls_trip <= 1'b0;
		else if (ls_over)
			ls_trip <= 1'b1;
		else if (cyc_end)
			ls_trip <= 1'b0;
	end
	logic good_q;
	logic fault_q;
	// Every output registered
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			reg_enable <= 1'b0;
			hs_allow <= 1'b0;
			ls_allow <= 1'b0;
			switch_node_float <= 1'b1;
			conv_mode <= 2'(BRS_DCM);
			reset_n <= 1'b0;
			good_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			reg_enable <= running;
			hs_allow <= running && !hs_over;
			ls_allow <= running && !ls_trip && !ls_over;
			switch_node_float <= !running || ls_trip || ls_over;
			conv_mode <= next_mode;
			reset_n <= above_95;
			good_q <= good;
			fault_q <= fault;
		end
	end

	// ----------------------------------------
	// Interrupt status, read data
	// ----------------------------------------
	wire good_fall = good_q && !good;
	wire fault_rise = fault && !fault_q;
	wire [7:0] ev = {6'h00, fault_rise, good_fall};
	wire [7:0] status_val = {6'h00, fault_q, good_q};
	// Event set wins over the read clear
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			irq_stat <= '0;
		else
			irq_stat <= (rd_stat ? 8'h00 : irq_stat) | ev;
	end
	wire [7:0] next_rdata = addr == ADDR_STATUS ? status_val
		: addr == ADDR_MODE ? mode_reg
		: addr == ADDR_IRQ_STAT ? irq_stat
		: addr == ADDR_IRQ_MASK ? irq_mask : 8'h00;
	// Read data stands one cycle; irq follows any unmasked status bit
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= '0;
			irq <= 1'b0;
		end else begin
			rdata <= rd ? next_rdata : 8'h00;
			irq <= |(irq_stat & irq_mask);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Switching clock: a spread period lapses at its end, not at once
	chk_ss_off_reset: assert property (@(posedge mclk)
		disable iff (!arst_n) cyc_end && !ss_en |=> period == 8'(SW_DIV))
		else $error("period varies with ss off");
	chk_ss_bound: assert property (@(posedge mclk)
		disable iff (!arst_n)
		period >= 8'(SW_DIV - SS_SPAN) && period <= 8'(SW_DIV + SS_SPAN))
		else $error("period outside spread band");

	// Current limits act in the cycle after the synchronised trip
	chk_hs_cut: assert property (@(posedge mclk)
		disable iff (!arst_n) hs_over |=> !hs_allow)
		else $error("high side not cut");
	chk_ls_hold: assert property (@(posedge mclk)
		disable iff (!arst_n)
		ls_over |=> ##1 !ls_allow && switch_node_float)
		else $error("low side not held off");

	// Hiccup entry, restart through soft-start, and repeat
	chk_run_drop: assert property (@(posedge mclk)
		disable iff (!arst_n)
		state == ST_RUN && !above_64 && !sw_dis && uvlo_ok
		|=> state == ST_HICCUP ##1 fault_q)
		else $error("no hiccup on low output");
	chk_retry_soft: assert property (@(posedge mclk)
		disable iff (!arst_n)
		state == ST_HICCUP && tmr_off_done && !sw_dis
		|=> state == ST_SOFT ##1 reg_enable && conv_mode == 2'(BRS_DCM))
		else $error("hiccup skipped soft start");
	chk_retry_again: assert property (@(posedge mclk)
		disable iff (!arst_n)
		state == ST_SOFT && tmr_soft_done && !above_95
		&& !sw_dis && uvlo_ok |=> ##1 !reg_enable && fault_q)
		else $error("failed restart not retried");

	// Status flags follow the comparators and the sequence
	chk_good_flag: assert property (@(posedge mclk)
		disable iff (!arst_n)
		good_q |-> $past(above_95) && $past(state) == ST_RUN)
		else $error("good flag without cause");
	chk_good_reset: assert property (@(posedge mclk)
		disable iff (!arst_n) !above_95 |=> !reset_n && !good_q)
		else $error("low output not flagged");
	chk_fault_retry: assert property (@(posedge mclk)
		disable iff (!arst_n)
		state == ST_SOFT && $past(state) == ST_HICCUP |=> fault_q)
		else $error("fault dropped during retry");
	chk_fault_clear: assert property (@(posedge mclk)
		disable iff (!arst_n)
		state == ST_RUN && above_64 && !hs_over && !ls_over |=> !fault_q)
		else $error("fault held in normal run");

	// Converter mode and software disable
	chk_soft_dcm: assert property (@(posedge mclk)
		disable iff (!arst_n) state == ST_SOFT |=> conv_mode == 2'(BRS_DCM))
		else $error("soft not dcm");
	chk_disable: assert property (@(posedge mclk)
		disable iff (!arst_n) sw_dis |=> ##1 !reg_enable)
		else $error("disable ignored");

	// Scenarios worth seeing at least once
	cov_hiccup: cover property (@(posedge mclk)
		state == ST_HICCUP ##1 state == ST_SOFT);
	cov_run: cover property (@(posedge mclk)
		state == ST_SOFT ##1 state == ST_RUN);
	cov_irq: cover property (@(posedge mclk) irq);
	cov_spread: cover property (@(posedge mclk) ss_en && cyc_end);
	cov_ls_trip: cover property (@(posedge mclk) ls_trip && !ls_over);
endmodule : brs_top
`default_nettype wire

// file: brs_stage_model.sv
// Behavioural buck power stage: output voltage comparators
`timescale 1ns/1ns
`default_nettype none
module brs_stage_model #(
	parameter int RAMP = 10
) (
	input wire logic mclk,
	input wire logic reg_enable,
	input wire logic shorted,
	output logic above_95,
	output logic above_64
);
	int level;
	// ----------------------------------------
	// Output ramps while enabled, collapses when off or shorted
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!reg_enable || shorted)
			level <= 0;
		else if (level < RAMP)
			level <= level + 1;
	end
	assign above_95 = level >= RAMP;
	assign above_64 = level >= RAMP / 2;
endmodule : brs_stage_model
`default_nettype wire

// file: buck_regulator_supervisor_tb.sv
// Self-checking bench for the buck regulator supervisor
`timescale 1ns/1ns
`default_nettype none
module buck_regulator_supervisor_tb;
	localparam int OFF = 50;
	localparam int SOFT = 30;
	logic mclk = 0, arst_n = 0, wr = 0, rd = 0, shorted = 0;
	logic hs_over = 0, ls_over = 0, uvlo_ok = 0, a95, a64;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, d;
	logic sw_clk, hs_allow, ls_allow, sn_float, reg_enable, reset_n, irq;
	logic [1:0] conv_mode;
	int n_errors = 0, tests_run = 0, n, i;
	always #4 mclk = ~mclk;
	brs_top #(.OFF_CYC(OFF), .SOFT_CYC(SOFT)) i_brs_top (.mclk(mclk),
		.arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .hs_over_async(hs_over), .ls_over_async(ls_over),
		.above_95_async(a95), .above_64_async(a64), .uvlo_ok_async(uvlo_ok),
		.sw_clk(sw_clk), .hs_allow(hs_allow), .ls_allow(ls_allow),
		.switch_node_float(sn_float), .reg_enable(reg_enable),
		.conv_mode(conv_mode), .reset_n(reset_n), .irq(irq));
	brs_stage_model #(.RAMP(10)) i_brs_stage_model (.mclk(mclk),
		.reg_enable(reg_enable), .shorted(shorted), .above_95(a95),
		.above_64(a64));
	// ----------------------------------------
	// Compare, bus and wait helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, got);
		tests_run++;
		if (exp !== got) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk("rdata", exp, rdata);
	endtask : rd_reg
	// Bounded wait for the enable, reset or switch level to reach v
	task automatic wait_sig(input int sel, input logic v, input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge mclk);
			#1 d = sel == 0 ? reg_enable : sel == 1 ? reset_n : hs_allow;
			if (sel == 3) d = ls_allow;
			if (d === v) return;
		end
		chk("wait", {7'h0, v}, d);
		tally_and_finish();
	endtask : wait_sig
	// Cycles between two rising edges of the switching clock
	task automatic period(output int p);
		for (i = 0; i < 300 && !(sw_clk === 1'b0); i++) @(posedge mclk);
		for (i = 0; i < 300 && !(sw_clk === 1'b1); i++) @(posedge mclk);
		for (p = 0; p < 300 && !(sw_clk === 1'b0); p++) @(posedge mclk);
		for (; p < 300 && !(sw_clk === 1'b1); p++) @(posedge mclk);
	endtask : period
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_start;
		rd_reg(4'h4, 8'h00);
		chk("enable", 8'h0, {7'h0, reg_enable});
		uvlo_ok <= 1'b1;
		wait_sig(0, 1'b1, 10);
		chk("soft mode", 8'h2, {6'h0, conv_mode});
		wait_sig(1, 1'b1, SOFT);
		repeat (4) @(posedge mclk);
		chk("run mode", 8'h0, {6'h0, conv_mode});
		rd_reg(4'h3, 8'h01);
		$display("startup done");
	endtask : t_start
	task automatic t_modes;
		logic [7:0] w[4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
		logic [1:0] m[4] = '{2'd0, 2'd1, 2'd2, 2'd2};
		for (int k = 0; k < 4; k++) begin
			wr_reg(4'h4, w[k]);
			rd_reg(4'h4, w[k]);
			chk("conv_mode", {6'h0, m[k]}, {6'h0, conv_mode});
		end
		rd_reg(4'hf, 8'h00);
		$display("modes done");
	endtask : t_modes
	task automatic t_spread;
		int p, odd;
		wr_reg(4'h4, 8'h00);
		period(p);
		chk("period", 8'd128, p[7:0]);
		wr_reg(4'h4, 8'h02);
		odd = 0;
		for (int k = 0; k < 6; k++) begin
			period(p);
			chk("in span", 8'h1, {7'h0, p >= 116 && p <= 140});
			odd += p != 128;
		end
		chk("jitter", 8'h1, {7'h0, odd > 0});
		wr_reg(4'h4, 8'h00);
		$display("spread done");
	endtask : t_spread
	task automatic t_over;
		hs_over <= 1'b1;
		wait_sig(2, 1'b0, 6);
		rd_reg(4'h3, 8'h03);
		hs_over <= 1'b0;
		ls_over <= 1'b1;
		wait_sig(3, 1'b0, 6);
		chk("float", 8'h1, {7'h0, sn_float});
		ls_over <= 1'b0;
		wait_sig(3, 1'b1, 270);
		rd_reg(4'h3, 8'h01);
		$display("overcurrent done");
	endtask : t_over
	task automatic t_hiccup;
		wr_reg(4'h9, 8'h03);
		rd_reg(4'h8, 8'h02);
		shorted <= 1'b1;
		wait_sig(0, 1'b0, 10);
		chk("reset_n", 8'h0, {7'h0, reset_n});
		rd_reg(4'h3, 8'h02);
		chk("irq", 8'h1, {7'h0, irq});
		wait_sig(0, 1'b1, OFF + 20);
		chk("off time", 8'h1, {7'h0, n >= OFF - 8 && n <= OFF});
		chk("retry mode", 8'h2, {6'h0, conv_mode});
		rd_reg(4'h3, 8'h02);
		wait_sig(0, 1'b0, SOFT + 10);
		shorted <= 1'b0;
		wait_sig(0, 1'b1, OFF + 20);
		wait_sig(1, 1'b1, SOFT);
		repeat (4) @(posedge mclk);
		rd_reg(4'h3, 8'h01);
		rd_reg(4'h8, 8'h03);
		repeat (2) @(posedge mclk);
		chk("irq clear", 8'h0, {7'h0, irq});
		wr_reg(4'h4, 8'h01);
		wait_sig(0, 1'b0, 6);
		$display("hiccup done");
	endtask : t_hiccup
	initial begin
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		t_start();
		t_modes();
		t_spread();
		t_over();
		t_hiccup();
		tally_and_finish();
	end
endmodule : buck_regulator_supervisor_tb
`default_nettype wire
